// file: rtl/psip_pkg.sv
// Purpose: Shared constants and types of the proximity sensor serial port
// Assumes: Word registers, low byte at bits 7:0, high byte at bits 15:8
// Notes: Field positions index the 16-bit word of a command code
`default_nettype none
package psip_pkg;
    // Bus target address
    localparam logic [6:0] DEV_ADDR = 7'h60;
    // Command codes
    localparam logic [7:0] CMD_RSVD0 = 8'h00;
    localparam logic [7:0] CMD_CONF12 = 8'h03;
    localparam logic [7:0] CMD_CONF3MS = 8'h04;
    localparam logic [7:0] CMD_CANC = 8'h05;
    localparam logic [7:0] CMD_THDL = 8'h06;
    localparam logic [7:0] CMD_THDH = 8'h07;
    localparam logic [7:0] CMD_DATA = 8'h08;
    localparam logic [7:0] CMD_FLAG = 8'h0B;
    localparam logic [7:0] CMD_ID = 8'h0C;
    // Reset values of the writable words
    localparam logic [15:0] RST_RSVD0 = 16'h0001;
    localparam logic [15:0] RST_CONF12 = 16'h0003;
    localparam logic [15:0] RST_OTHER = 16'h0000;
    // Field positions inside words
    localparam int SD_BIT = 0;      // Shutdown, 1 = measurement off
    localparam int IT_LSB = 1;      // Integration period select, 3 bits
    localparam int PERS_LSB = 4;    // Persistence, 2 bits, 1 to 4 samples
    localparam int INTEN_BIT = 8;   // Interrupt enable
    localparam int HD_BIT = 11;     // 1 = 16-bit result
    localparam int CUR_LSB = 8;     // Emitter current code, 3 bits
    localparam int AWAY_BIT = 8;    // Flag word: fell below low threshold
    localparam int CLOSE_BIT = 9;   // Flag word: rose above high threshold
    // Full scale of the result
    localparam logic [15:0] FS12 = 16'h0FFF;
    // Emitter sink current in mA
    localparam logic [7:0] CUR_MIN_MA = 8'h32;
    localparam logic [7:0] CUR_STEP_MA = 8'h19;
    localparam logic [7:0] CUR_MAX_MA = 8'hC8;
    localparam logic [2:0] CUR_TOP_CODE = 3'h6;
    // Byte phases of a transfer
    localparam logic [1:0] PH_ADDR = 2'h0;
    localparam logic [1:0] PH_CMD = 2'h1;
    localparam logic [1:0] PH_LO = 2'h2;
    localparam logic [1:0] PH_HI = 2'h3;
    localparam logic [3:0] BITS_DONE = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    // Serial engine states
    typedef enum logic [2:0] {S_IDLE, S_RECV, S_ACK, S_SEND, S_HACK} psip_state_e;
    // Writable words: the reserved word 0 and codes 3 to 7
    function automatic logic isWritable(input logic [7:0] c);
        isWritable = (c == CMD_RSVD0) || ((c >= CMD_CONF12) && (c <= CMD_THDH));
    endfunction : isWritable
endpackage : psip_pkg
`default_nettype wire

// file: rtl/psip_line_if.sv
// Purpose: Bus line events passed from the line conditioner to the engine
// Assumes: All signals on mclk, events are one-cycle pulses
// Notes: Produced by psip_line_sync only
`default_nettype none
interface psip_line_if;
    logic sclRise;   // Clock rose
    logic sclFall;   // Clock fell
    logic startCond; // Start or repeated start
    logic stopCond;  // Stop
    logic sdaBit;    // Settled data level
    modport prod (output sclRise, sclFall, startCond, stopCond, sdaBit);
    modport cons (input sclRise, sclFall, startCond, stopCond, sdaBit);
endinterface : psip_line_if
`default_nettype wire

// file: rtl/psip_line_sync.sv
// Purpose: Synchronise bus pins and detect edges, start and stop
// Assumes: mclk well above the bus clock rate
// Notes: The first stage of each pin is read only by the second
`default_nettype none
module psip_line_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    // Events out
    psip_line_if.prod ln
);
    logic [2:0] scl_r;   // Two sync stages plus previous value
    logic [2:0] sda_r;
    logic [2:0] scl_nxt;
    logic [2:0] sda_nxt;

    // Shift chains, idle bus level is high
    always_comb begin
        scl_nxt = {scl_r[1:0], sclIn};
        sda_nxt = {sda_r[1:0], sdaIn};
    end

    // Registers only
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            scl_r <= 3'h7;
            sda_r <= 3'h7;
        end else begin
            scl_r <= scl_nxt;
            sda_r <= sda_nxt;
        end
    end

    // Events from settled stages only; data change with clock high marks framing
    assign ln.sclRise = scl_r[1] & ~scl_r[2];
    assign ln.sclFall = ~scl_r[1] & scl_r[2];
    assign ln.startCond = scl_r[1] & scl_r[2] & ~sda_r[1] & sda_r[2];
    assign ln.stopCond = scl_r[1] & scl_r[2] & sda_r[1] & ~sda_r[2];
    assign ln.sdaBit = sda_r[1];
endmodule : psip_line_sync
`default_nettype wire

// file: rtl/psip_top.sv
// Purpose: Serial word-access register port of a proximity sensor
// Assumes: Host is bus master and makes the bus clock; samples come from outside
// Notes: Data pin is open drain, driven only low
`default_nettype none
// Functional notes
// - Answer only target address 0x60
// - All access goes through command codes
// - Word transfers: address, command, two bytes
// - Acknowledge every byte the host drives, up to the high data byte
// - Reading flag word clears interrupt
// - Result saturates at 12 or 16 bits
// - Emitter current selectable 50 to 200 mA
// - Eight-bit command selects low/high pair
// - Interrupt beyond thresholds after persistence
module psip_top #(
    parameter logic [15:0] ID_WORD = 16'h0A5A // Arbitrary identity value
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Serial bus
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Measurement side
    input wire logic [15:0] sampleRaw,
    input wire logic sampleValid,
    output logic measEnable,
    output logic [2:0] integrationPeriodSelect,
    output logic resolution16,
    output logic [7:0] emitterDriveMa,
    // Interrupt, active low
    output logic intN
);
    psip_line_if ln ();
    psip_line_sync u_sync (.mclk(mclk), .rstn(rstn), .sclIn(sclIn), .sdaIn(sdaIn), .ln(ln));

    // Serial engine state
    psip_pkg::psip_state_e state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;     // Bit count in byte
    logic [7:0] sh_r, sh_nxt;       // Shift register
    logic [1:0] ph_r, ph_nxt;       // Byte phase
    logic [7:0] cmd_r, cmd_nxt;     // Command code, kept over repeated start
    logic [7:0] lo_r, lo_nxt;       // Low byte written, or latched high byte on read
    logic rd_r, rd_nxt;             // Read direction
    logic oe_r, oe_nxt;             // Pulling data low
    logic wrEn;                     // Word complete
    logic flagRd;                   // Flag word high byte handed out
    logic [15:0] rdVal;             // Word selected by the command
    // Registers
    logic [15:0] cfg_r [0:7];
    logic [15:0] cfg_nxt [0:7];
    logic [7:0] drv_r, drv_nxt;
    logic [2:0] curCode;
    // Measurement
    logic [15:0] data_r, data_nxt, sat;
    logic [1:0] flag_r, flag_nxt;   // {close, away}
    logic [1:0] hiCnt_r, hiCnt_nxt, loCnt_r, loCnt_nxt;
    logic int_r, int_nxt;
    logic evtClose, evtAway, addrBad;

    // Word seen by the host for the current command
    always_comb begin
        case (cmd_r)
            psip_pkg::CMD_RSVD0, psip_pkg::CMD_CONF12, psip_pkg::CMD_CONF3MS,
            psip_pkg::CMD_CANC, psip_pkg::CMD_THDL, psip_pkg::CMD_THDH: rdVal = cfg_r[cmd_r[2:0]];
            psip_pkg::CMD_DATA: rdVal = data_r;
            psip_pkg::CMD_FLAG: rdVal = {6'h00, flag_r, 8'h00};
            psip_pkg::CMD_ID: rdVal = ID_WORD;
            default: rdVal = 16'h0000; // Unmapped codes read zero
        endcase
    end

    assign addrBad = (ph_r == psip_pkg::PH_ADDR) && (sh_r[7:1] != psip_pkg::DEV_ADDR);

    // Serial engine next state; stop and start override any byte in progress
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        ph_nxt = ph_r;
        cmd_nxt = cmd_r;
        lo_nxt = lo_r;
        rd_nxt = rd_r;
        oe_nxt = oe_r;
        wrEn = 1'b0;
        flagRd = 1'b0;
        if (ln.stopCond) begin
            state_nxt = psip_pkg::S_IDLE;
            oe_nxt = 1'b0;
        end else if (ln.startCond) begin
            state_nxt = psip_pkg::S_RECV;
            ph_nxt = psip_pkg::PH_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end else begin
            case (state_r)
                psip_pkg::S_RECV: begin
                    if (ln.sclRise) begin
                        sh_nxt = {sh_r[6:0], ln.sdaBit};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (ln.sclFall && cnt_r == psip_pkg::BITS_DONE) begin
                        if (addrBad) begin
                            state_nxt = psip_pkg::S_IDLE;
                        end else begin
                            state_nxt = psip_pkg::S_ACK;
                            oe_nxt = 1'b1;
                            case (ph_r)
                                psip_pkg::PH_ADDR: rd_nxt = sh_r[0];
                                psip_pkg::PH_CMD: cmd_nxt = sh_r;
                                psip_pkg::PH_LO: lo_nxt = sh_r;
                                default: wrEn = 1'b1;
                            endcase
                        end
                    end
                end
                psip_pkg::S_ACK: begin
                    if (ln.sclFall) begin
                        cnt_nxt = 4'h0;
                        if (ph_r == psip_pkg::PH_ADDR && rd_r) begin
                            // low byte first, high byte held for coherence
                            state_nxt = psip_pkg::S_SEND;
                            ph_nxt = psip_pkg::PH_LO;
                            sh_nxt = rdVal[7:0];
                            lo_nxt = rdVal[15:8];
                            oe_nxt = ~rdVal[7];
                        end else if (ph_r == psip_pkg::PH_HI) begin
                            // Extra bytes get no acknowledge
                            state_nxt = psip_pkg::S_IDLE;
                            oe_nxt = 1'b0;
                        end else begin
                            state_nxt = psip_pkg::S_RECV;
                            ph_nxt = ph_r + 2'h1;
                            oe_nxt = 1'b0;
                        end
                    end
                end
                psip_pkg::S_SEND: begin
                    if (ln.sclFall) begin
                        if (cnt_r == psip_pkg::LAST_BIT) begin
                            state_nxt = psip_pkg::S_HACK;
                            oe_nxt = 1'b0;
                        end else begin
                            sh_nxt = {sh_r[6:0], 1'b0};
                            cnt_nxt = cnt_r + 4'h1;
                            oe_nxt = ~sh_r[6];
                        end
                    end
                end
                psip_pkg::S_HACK: begin
                    if (ln.sclRise && ln.sdaBit) begin
                        state_nxt = psip_pkg::S_IDLE; // Host declined more
                    end else if (ln.sclFall) begin
                        cnt_nxt = 4'h0;
                        if (ph_r == psip_pkg::PH_LO) begin
                            state_nxt = psip_pkg::S_SEND;
                            ph_nxt = psip_pkg::PH_HI;
                            sh_nxt = lo_r;
                            oe_nxt = ~lo_r[7];
                            flagRd = (cmd_r == psip_pkg::CMD_FLAG);
                        end else begin
                            state_nxt = psip_pkg::S_IDLE;
                        end
                    end
                end
                default: state_nxt = psip_pkg::S_IDLE;
            endcase
        end
    end

    // Serial engine registers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r <= psip_pkg::S_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            ph_r <= psip_pkg::PH_ADDR;
            cmd_r <= 8'h00;
            lo_r <= 8'h00;
            rd_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            ph_r <= ph_nxt;
            cmd_r <= cmd_nxt;
            lo_r <= lo_nxt;
            rd_r <= rd_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe = oe_r;

    // Register words and emitter current; writes to read-only codes are dropped
    always_comb begin
        cfg_nxt = cfg_r;
        if (wrEn && psip_pkg::isWritable(cmd_r)) begin
            cfg_nxt[cmd_r[2:0]] = {sh_r, lo_r};
        end
        // code 6 and above give the maximum
        curCode = cfg_r[psip_pkg::CMD_CONF3MS[2:0]][psip_pkg::CUR_LSB +: 3];
        if (curCode >= psip_pkg::CUR_TOP_CODE) begin
            drv_nxt = psip_pkg::CUR_MAX_MA;
        end else begin
            drv_nxt = 8'(psip_pkg::CUR_MIN_MA + {5'h00, curCode} * psip_pkg::CUR_STEP_MA);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 8; i++) begin
                cfg_r[i] <= (i == 0) ? psip_pkg::RST_RSVD0 :
                            (i == 3) ? psip_pkg::RST_CONF12 : psip_pkg::RST_OTHER;
            end
            drv_r <= psip_pkg::CUR_MIN_MA;
        end else begin
            cfg_r <= cfg_nxt;
            drv_r <= drv_nxt;
        end
    end

    assign emitterDriveMa = drv_r;
    assign measEnable = ~cfg_r[psip_pkg::CMD_CONF12[2:0]][psip_pkg::SD_BIT];
    assign integrationPeriodSelect = cfg_r[psip_pkg::CMD_CONF12[2:0]][psip_pkg::IT_LSB +: 3];
    assign resolution16 = cfg_r[psip_pkg::CMD_CONF12[2:0]][psip_pkg::HD_BIT];

    // Result, persistence and flags; a new event wins over a clearing read
    always_comb begin
        sat = (resolution16 || sampleRaw <= psip_pkg::FS12) ? sampleRaw : psip_pkg::FS12;
        data_nxt = sampleValid ? sat : data_r;
        hiCnt_nxt = hiCnt_r;
        loCnt_nxt = loCnt_r;
        evtClose = 1'b0;
        evtAway = 1'b0;
        if (sampleValid) begin
            if (sat > cfg_r[psip_pkg::CMD_THDH[2:0]]) begin
                evtClose = (hiCnt_r == cfg_r[psip_pkg::CMD_CONF12[2:0]][psip_pkg::PERS_LSB +: 2]);
                hiCnt_nxt = evtClose ? hiCnt_r : hiCnt_r + 2'h1;
            end else begin
                hiCnt_nxt = 2'h0;
            end
            if (sat < cfg_r[psip_pkg::CMD_THDL[2:0]]) begin
                evtAway = (loCnt_r == cfg_r[psip_pkg::CMD_CONF12[2:0]][psip_pkg::PERS_LSB +: 2]);
                loCnt_nxt = evtAway ? loCnt_r : loCnt_r + 2'h1;
            end else begin
                loCnt_nxt = 2'h0;
            end
        end
        flag_nxt = flagRd ? 2'h0 : flag_r;
        if (cfg_r[psip_pkg::CMD_CONF12[2:0]][psip_pkg::INTEN_BIT]) begin
            flag_nxt = flag_nxt | {evtClose, evtAway};
        end
        int_nxt = |flag_nxt;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            data_r <= 16'h0000;
            flag_r <= 2'h0;
            hiCnt_r <= 2'h0;
            loCnt_r <= 2'h0;
            int_r <= 1'b0;
        end else begin
            data_r <= data_nxt;
            flag_r <= flag_nxt;
            hiCnt_r <= hiCnt_nxt;
            loCnt_r <= loCnt_nxt;
            int_r <= int_nxt;
        end
    end

    assign intN = ~int_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire byteEnd = state_r == psip_pkg::S_RECV && ln.sclFall && cnt_r == psip_pkg::BITS_DONE
                   && !ln.stopCond && !ln.startCond;
    wire rdTurn = state_r == psip_pkg::S_ACK && ln.sclFall && rd_r && ph_r == psip_pkg::PH_ADDR
                  && !ln.stopCond && !ln.startCond;

    property p_addr_ignore;
        byteEnd && addrBad |=> state_r == psip_pkg::S_IDLE && !sdaOe;
    endproperty
    a_addr_ignore: assert property (p_addr_ignore) else $error("foreign address answered");
    property p_ack_drive;
        byteEnd && !addrBad |=> sdaOe && state_r == psip_pkg::S_ACK;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("byte not acknowledged");
    property p_word_write;
        wrEn && cmd_r == psip_pkg::CMD_THDH |=> cfg_r[7] == {$past(sh_r), $past(lo_r)};
    endproperty
    a_word_write: assert property (p_word_write) else $error("word write not stored");
    property p_read_turn;
        rdTurn |=> state_r == psip_pkg::S_SEND && ph_r == psip_pkg::PH_LO;
    endproperty
    a_read_turn: assert property (p_read_turn) else $error("read did not start sending");
    property p_low_first;
        rdTurn |=> sh_r == $past(rdVal[7:0]) && lo_r == $past(rdVal[15:8]);
    endproperty
    a_low_first: assert property (p_low_first) else $error("low byte not sent first");
    property p_flag_clear;
        flagRd && !evtClose && !evtAway |=> flag_r == 2'h0 && intN;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag read did not clear");
    property p_saturate;
        sampleValid && !resolution16 |=> data_r <= psip_pkg::FS12;
    endproperty
    a_saturate: assert property (p_saturate) else $error("12-bit result over range");
    property p_current;
        emitterDriveMa >= psip_pkg::CUR_MIN_MA && emitterDriveMa <= psip_pkg::CUR_MAX_MA;
    endproperty
    a_current: assert property (p_current) else $error("emitter current out of range");
    property p_int_set;
        evtClose && cfg_r[3][psip_pkg::INTEN_BIT] |=> flag_r[1] && !intN;
    endproperty
    a_int_set: assert property (p_int_set) else $error("interrupt not raised");
    property p_stop_idle;
        ln.stopCond |=> state_r == psip_pkg::S_IDLE && !sdaOe;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");
    c_write: cover property (wrEn);
    c_read_hi: cover property (flagRd);
    c_sat: cover property (sampleValid && !resolution16 && sampleRaw > psip_pkg::FS12);
endmodule : psip_top
`default_nettype wire

// file: test/psip_host_model.sv
// Purpose: Behavioural bus master that runs word transfers into the port
// Assumes: Both bus lines pulled up; one bus bit lasts 16 mclk
// Notes: The bench calls the transfer tasks through the instance name
`default_nettype none
module psip_host_model (
    // Clock
    input wire logic mclk,
    // Device side of the data wire
    input wire logic sdaOe,
    input wire logic sdaOut,
    // Resolved bus lines
    output logic sclPin,
    output wire logic sdaPin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic hostLow = 1'b0; // Host pulls data low
    // Open drain: pull-up wins unless someone pulls low
    assign sdaPin = !(hostLow || (sdaOe && !sdaOut));
    // Clock idles high, and stands still between frames
    initial sclPin = 1'b1;
    // Quarter of a bus bit
    task automatic quarter();
        repeat (4) @(posedge mclk);
    endtask : quarter
    // One bit slot; data changes only while the clock is low
    task automatic bitSlot(input logic pullLow, output logic seen);
        hostLow <= pullLow;
        quarter();
        sclPin <= 1'b1;
        quarter();
        #1 seen = sdaPin;
        quarter();
        sclPin <= 1'b0;
        quarter();
    endtask : bitSlot
    task automatic startCond();
        @(posedge mclk);
        hostLow <= 1'b0;
        quarter();
        sclPin <= 1'b1;
        quarter();
        hostLow <= 1'b1;
        quarter();
        sclPin <= 1'b0;
        quarter();
    endtask : startCond
    task automatic stopCond();
        hostLow <= 1'b1;
        quarter();
        sclPin <= 1'b1;
        quarter();
        hostLow <= 1'b0;
        quarter();
    endtask : stopCond
    // Eight bits, most significant first, then the acknowledge slot
    task automatic byteIo(input logic [7:0] tx, input logic pull9, output logic [7:0] rx,
                          output logic bit9);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bitSlot(!tx[i], b);
            rx[i] = b;
        end
        bitSlot(pull9, bit9);
    endtask : byteIo
    task automatic wrWord(input logic [6:0] addr, input logic [7:0] cmd,
                          input logic [15:0] data, output logic [3:0] acks);
        logic [7:0] rx;
        logic a;
        startCond();
        byteIo({addr, 1'b0}, 1'b0, rx, a);
        acks[3] = !a;
        byteIo(cmd, 1'b0, rx, a);
        acks[2] = !a;
        byteIo(data[7:0], 1'b0, rx, a);
        acks[1] = !a;
        byteIo(data[15:8], 1'b0, rx, a);
        acks[0] = !a;
        stopCond();
    endtask : wrWord
    // one word read after a repeated start, host nacks the high byte
    task automatic rdWord(input logic [6:0] addr, input logic [7:0] cmd,
                          output logic [15:0] data, output logic [2:0] acks);
        logic [7:0] rx;
        logic a;
        startCond();
        byteIo({addr, 1'b0}, 1'b0, rx, a);
        acks[2] = !a;
        byteIo(cmd, 1'b0, rx, a);
        acks[1] = !a;
        startCond();
        byteIo({addr, 1'b1}, 1'b0, rx, a);
        acks[0] = !a;
        byteIo(8'hFF, 1'b1, rx, a);
        data[7:0] = rx;
        byteIo(8'hFF, 1'b0, rx, a);
        data[15:8] = rx;
        stopCond();
    endtask : rdWord
endmodule : psip_host_model
`default_nettype wire

// file: test/psip_top_test.sv
// Purpose: Self-checking bench for the proximity sensor serial port
// Assumes: Host model drives the bus, bench drives the samples
// Notes: Every check waits 1 ns so that edge updates have landed
`default_nettype none
module psip_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] ID_VAL = 16'h3C96; // Arbitrary identity value
    localparam logic [6:0] ADDR = 7'h60; // Our target address
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] sampleRaw = 16'h0000;
    logic sampleValid = 1'b0;
    wire logic sclIn;
    wire logic sdaIn;
    logic sdaOut;
    logic sdaOe;
    logic measEnable;
    logic [2:0] integrationPeriodSelect;
    logic resolution16;
    logic [7:0] emitterDriveMa;
    logic intN;
    int badCount = 0; // Mismatches
    int cmpCount = 0; // Comparisons
    logic [3:0] wa; // Write acknowledges
    logic [2:0] ra; // Read acknowledges
    logic [15:0] rw; // Read word
    // 25 MHz clock
    always #20 mclk = ~mclk;
    psip_top #(.ID_WORD(ID_VAL)) uut (.mclk(mclk), .rstn(rstn), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .sampleRaw(sampleRaw), .sampleValid(sampleValid),
        .measEnable(measEnable), .integrationPeriodSelect(integrationPeriodSelect),
        .resolution16(resolution16), .emitterDriveMa(emitterDriveMa), .intN(intN));
    psip_host_model host (.mclk(mclk), .sdaOe(sdaOe), .sdaOut(sdaOut), .sclPin(sclIn),
        .sdaPin(sdaIn));
    // Compare after the edge settles
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        #1;
        cmpCount++;
        if (seen !== exp) begin
            badCount++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic giveVerdict();
        if (badCount == 0 && cmpCount > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : giveVerdict
    // One sample pulse, then a few cycles for flags to land
    task automatic sendSample(input logic [15:0] v);
        @(posedge mclk);
        sampleRaw <= v;
        sampleValid <= 1'b1;
        @(posedge mclk);
        sampleValid <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : sendSample
    task automatic testReset();
        chk(16'(sdaOe), 16'h0000);
        chk(16'(sdaOut), 16'h0000);
        chk(16'(intN), 16'h0001);
        chk(16'(measEnable), 16'h0000);
        chk(16'(integrationPeriodSelect), 16'h0001);
        chk(16'(resolution16), 16'h0000);
        chk(16'(emitterDriveMa), 16'h0032);
    endtask : testReset
    // Foreign target is ignored and leaves the settings alone
    task automatic testAddress();
        host.wrWord(7'h61, 8'h03, 16'h0000, wa);
        chk(16'(wa), 16'h0000);
        chk(16'(measEnable), 16'h0000);
    endtask : testAddress
    // Word write, every byte acknowledged, read back in byte order
    task automatic testConfig();
        host.wrWord(ADDR, 8'h03, 16'h080A, wa);
        chk(16'(wa), 16'h000F);
        repeat (4) @(posedge mclk);
        chk(16'(measEnable), 16'h0001);
        chk(16'(integrationPeriodSelect), 16'h0005);
        chk(16'(resolution16), 16'h0001);
        host.rdWord(ADDR, 8'h03, rw, ra);
        chk(16'(ra), 16'h0007);
        chk(rw, 16'h080A);
    endtask : testConfig
    // Every current code, saturating at the top
    task automatic testEmitter();
        for (int c = 0; c < 8; c++) begin
            host.wrWord(ADDR, 8'h04, 16'(c << 8), wa);
            repeat (4) @(posedge mclk);
            chk(16'(emitterDriveMa), (c >= 6) ? 16'h00C8 : 16'(16'h0032 + 16'h0019 * c));
        end
    endtask : testEmitter
    // Unmapped and read-only codes drop writes, fixed words read back
    task automatic testReserved();
        host.wrWord(ADDR, 8'h01, 16'h5555, wa);
        chk(16'(wa), 16'h000F);
        // Result code shares index 0 with word 0, so a stored write would show there
        host.wrWord(ADDR, 8'h08, 16'h5555, wa);
        chk(16'(wa), 16'h000F);
        host.wrWord(ADDR, 8'h05, 16'hA55A, wa);
        host.rdWord(ADDR, 8'h05, rw, ra);
        chk(rw, 16'hA55A);
        host.rdWord(ADDR, 8'h01, rw, ra);
        chk(rw, 16'h0000);
        host.rdWord(ADDR, 8'h00, rw, ra);
        chk(rw, 16'h0001);
        host.rdWord(ADDR, 8'h0C, rw, ra);
        chk(rw, ID_VAL);
    endtask : testReserved
    // Full scale in both resolutions
    task automatic testRange();
        host.wrWord(ADDR, 8'h03, 16'h000A, wa);
        sendSample(16'hFFFF);
        host.rdWord(ADDR, 8'h08, rw, ra);
        chk(rw, 16'h0FFF);
        host.wrWord(ADDR, 8'h03, 16'h080A, wa);
        sendSample(16'hFFFF);
        host.rdWord(ADDR, 8'h08, rw, ra);
        chk(rw, 16'hFFFF);
    endtask : testRange
    // Crossing each threshold, persistence, clear on flag read
    task automatic testInterrupt();
        host.wrWord(ADDR, 8'h07, 16'h0100, wa);
        host.wrWord(ADDR, 8'h06, 16'h0010, wa);
        host.wrWord(ADDR, 8'h03, 16'h010A, wa);
        sendSample(16'h0200);
        chk(16'(intN), 16'h0000);
        host.rdWord(ADDR, 8'h0B, rw, ra);
        chk(rw, 16'h0200);
        chk(16'(intN), 16'h0001);
        host.wrWord(ADDR, 8'h03, 16'h011A, wa);
        sendSample(16'h0005);
        chk(16'(intN), 16'h0001);
        sendSample(16'h0005);
        chk(16'(intN), 16'h0000);
        host.rdWord(ADDR, 8'h0B, rw, ra);
        chk(rw, 16'h0100);
        chk(16'(intN), 16'h0001);
    endtask : testInterrupt
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        repeat (4) @(posedge mclk);
        testReset();
        testAddress();
        testConfig();
        testEmitter();
        testReserved();
        testRange();
        testInterrupt();
        giveVerdict();
    end
    // Watchdog, about twice the expected run
    initial begin
        repeat (40000) @(posedge mclk);
        badCount++;
        giveVerdict();
    end
endmodule : psip_top_test
`default_nettype wire
